/* cbi_bus_irq.v */
`timescale 1ns/1ns
`include "cbi_regs.vh"
// Contract
// - upper address out, floated hold/halt/reset
// - low address in T1, data T2-T3
// - latch strobe pulses each T1, never floated
// - two status bits encode cycle type
// - read strobe low selects read, floats hold/halt
// - write strobe low while write data valid
// - ready low inserts whole wait states
// - hold releases buses after current cycle
// - hold floats address, data, read/write strobes, select
// - grant announces release, retake after drop
// - sample general request next-to-last clock
// - software enables; reset and accept disable
// - acknowledge strobe replaces read strobe
// - restart inputs inserted internally, same timing
// - fixed priority 7.5, 6.5, 5.5, general
// - trap ignores masks and enable, top priority
// - restart vectors 24, 2C, 34, 3C hex
// - 7.5 edge flop, cleared serviced/mask-set/reset
// - any service disables all but trap
module cbi_bus_irq #(
  parameter NSYNC = 15
) (
  input wire sys_clk,
  input wire rst_n,
  input wire cyc_req,
  input wire [2:0] cyc_type,
  input wire [15:0] cyc_addr,
  input wire [7:0] cyc_wdata,
  input wire halt_req,
  input wire irq_sample,
  input wire enable_irq_instruction,
  input wire disable_irq_instruction,
  input wire mask_set_instruction,
  input wire [7:0] mask_set_data,
  input wire ready_in,
  input wire hold_in,
  input wire general_irq_in,
  input wire rst55_in,
  input wire rst65_in,
  input wire rst75_in,
  input wire trap_in,
  input wire [7:0] shared_addr_data_in,
  output reg [7:0] shared_addr_data_bus,
  output reg shared_addr_data_oe_n,
  output reg [7:0] upper_address_out,
  output reg upper_address_oe_n,
  output reg ale_r,
  output reg cycle_status_low,
  output reg cycle_status_high,
  output reg io_m_r,
  output reg io_m_oe_n,
  output reg rd_n_r,
  output reg rd_oe_n,
  output reg wr_n_r,
  output reg wr_oe_n,
  output reg irq_acknowledge_n,
  output reg bus_grant_out,
  output reg cyc_done_r,
  output reg [7:0] cyc_rdata_r,
  output reg irq_take_r,
  output reg [7:0] irq_vec_r,
  output reg irq_ext_r,
  output reg irq_enabled_r,
  output reg [2:0] irq_mask_r,
  output reg rst75_pend_r
);
  // ----------------------------------------
  // bus sequencer states
  // ----------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_T1 = 3'h1;
  localparam S_T2 = 3'h2;
  localparam S_TW = 3'h3;
  localparam S_T3 = 3'h4;
  localparam S_HACK = 3'h5;
  localparam S_HOLD = 3'h6;
  localparam S_HREL = 3'h7;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] typ_r;
  reg [15:0] addr_r;
  reg [7:0] wd_r;
  reg [NSYNC-1:0] sync1_r;
  reg [NSYNC-1:0] sync2_r;
  reg trap_d_r;
  reg r75_d_r;
  reg trap_arm_r;
  reg done_pend_r;
  wire [NSYNC-1:0] sync_in;
  wire ready_s;
  wire hold_s;
  wire general_irq_in_s;
  wire r55_s;
  wire r65_s;
  wire r75_s;
  wire trap_s;
  wire [7:0] ad_s;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  assign sync_in = {shared_addr_data_in, trap_in, rst75_in, rst65_in,
                    rst55_in, general_irq_in, hold_in, ready_in};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      // only the second stage is ever read
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= sync_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate
  assign ready_s = sync2_r[0];
  assign hold_s = sync2_r[1];
  assign general_irq_in_s = sync2_r[2];
  assign r55_s = sync2_r[3];
  assign r65_s = sync2_r[4];
  assign r75_s = sync2_r[5];
  assign trap_s = sync2_r[6];
  assign ad_s = sync2_r[14:7];

  // ----------------------------------------
  // machine cycle sequencer
  // ----------------------------------------
  wire accept;
  wire [2:0] t_nxt;
  wire [15:0] a_nxt;
  wire [7:0] wd_nxt;
  // a pending or raised done blocks a retake of the request just finished
  assign accept = (state_r == S_IDLE) & cyc_req & ~cyc_done_r & ~done_pend_r & ~halt_req &
                  ~hold_s;
  assign t_nxt = accept ? cyc_type : typ_r;
  assign a_nxt = accept ? cyc_addr : addr_r;
  assign wd_nxt = accept ? cyc_wdata : wd_r;

  // next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (hold_s) begin
          state_nxt = S_HACK;
        end else if (accept) begin
          state_nxt = S_T1;
        end
      end
      S_T1: state_nxt = S_T2;
      S_T2, S_TW: begin
        state_nxt = ready_s ? S_T3 : S_TW;
      end
      S_T3: state_nxt = hold_s ? S_HACK : S_IDLE;
      S_HACK: state_nxt = S_HOLD;
      S_HOLD: state_nxt = hold_s ? S_HOLD : S_HREL;
      S_HREL: state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  // decode of the next state, so every pin comes from a flop
  wire in_cyc;
  wire strobe_t;
  wire is_wr;
  wire is_io;
  wire ctl_on;
  reg [1:0] st_code;
  assign in_cyc = (state_nxt == S_T1) | (state_nxt == S_T2) | (state_nxt == S_TW) |
                  (state_nxt == S_T3);
  assign strobe_t = in_cyc & (state_nxt != S_T1);
  assign is_wr = (t_nxt == `CBI_CYC_MWR) | (t_nxt == `CBI_CYC_IOWR);
  assign is_io = (t_nxt == `CBI_CYC_IORD) | (t_nxt == `CBI_CYC_IOWR) |
                 (t_nxt == `CBI_CYC_IRQ_ACKNOWLEDGE_N);
  // in idle and hold acknowledge the select lines stay driven unless halted
  assign ctl_on = in_cyc | (((state_nxt == S_IDLE) | (state_nxt == S_HACK)) & ~halt_req);

  always @* begin
    case (t_nxt)
      `CBI_CYC_MWR, `CBI_CYC_IOWR: st_code = `CBI_ST_WRITE;
      `CBI_CYC_MRD, `CBI_CYC_IORD: st_code = `CBI_ST_READ;
      default: st_code = `CBI_ST_FETCH;
    endcase
  end

  // pin registers
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      typ_r <= `CBI_CYC_MRD;
      addr_r <= 16'h0000;
      wd_r <= 8'h00;
      shared_addr_data_bus <= 8'h00;
      shared_addr_data_oe_n <= 1'b1;
      upper_address_out <= 8'h00;
      upper_address_oe_n <= 1'b1;
      ale_r <= 1'b0;
      cycle_status_low <= 1'b0;
      cycle_status_high <= 1'b0;
      io_m_r <= 1'b0;
      io_m_oe_n <= 1'b1;
      rd_n_r <= 1'b1;
      rd_oe_n <= 1'b1;
      wr_n_r <= 1'b1;
      wr_oe_n <= 1'b1;
      irq_acknowledge_n <= 1'b1;
      bus_grant_out <= 1'b0;
      cyc_done_r <= 1'b0;
      done_pend_r <= 1'b0;
      cyc_rdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      typ_r <= t_nxt;
      addr_r <= a_nxt;
      wd_r <= wd_nxt;
      // io cycles repeat the port number on the upper lines
      upper_address_out <= is_io ? a_nxt[7:0] : a_nxt[15:8];
      upper_address_oe_n <= ~ctl_on;
      ale_r <= (state_nxt == S_T1);
      shared_addr_data_bus <= (state_nxt == S_T1) ? a_nxt[7:0] : wd_nxt;
      shared_addr_data_oe_n <= ~((state_nxt == S_T1) | (strobe_t & is_wr));
      if (in_cyc) begin
        {cycle_status_high, cycle_status_low} <= st_code;
        io_m_r <= is_io;
      end else if (halt_req) begin
        {cycle_status_high, cycle_status_low} <= `CBI_ST_HALT;
      end
      io_m_oe_n <= ~ctl_on;
      rd_n_r <= ~(strobe_t & ~is_wr & (t_nxt != `CBI_CYC_IRQ_ACKNOWLEDGE_N));
      rd_oe_n <= ~ctl_on;
      wr_n_r <= ~(strobe_t & is_wr);
      wr_oe_n <= ~ctl_on;
      irq_acknowledge_n <= ~(strobe_t & (t_nxt == `CBI_CYC_IRQ_ACKNOWLEDGE_N));
      bus_grant_out <= (state_nxt == S_HACK) | (state_nxt == S_HOLD);
      // data pins are two flops late, so the answer trails T3 by two clocks
      done_pend_r <= (state_r == S_T3);
      cyc_done_r <= done_pend_r;
      if (done_pend_r) begin
        cyc_rdata_r <= ad_s;
      end
    end
  end

  // ----------------------------------------
  // interrupt recognition
  // ----------------------------------------
  wire r75_rise;
  wire trap_rise;
  wire trap_req;
  reg [2:0] pick;
  reg [7:0] vec;
  assign r75_rise = r75_s & ~r75_d_r;
  assign trap_rise = trap_s & ~trap_d_r;
  // edge arms, level must still be high when sampled
  assign trap_req = trap_arm_r & trap_s;

  // pick codes: 1 trap, 2 r75, 3 r65, 4 r55, 5 general
  always @* begin
    pick = 3'h0;
    vec = `CBI_VEC_NONE;
    if (trap_req) begin
      pick = 3'h1;
      vec = `CBI_VEC_TRAP;
    end else if (irq_enabled_r & rst75_pend_r & ~irq_mask_r[2]) begin
      pick = 3'h2;
      vec = `CBI_VEC_R75;
    end else if (irq_enabled_r & r65_s & ~irq_mask_r[1]) begin
      pick = 3'h3;
      vec = `CBI_VEC_R65;
    end else if (irq_enabled_r & r55_s & ~irq_mask_r[0]) begin
      pick = 3'h4;
      vec = `CBI_VEC_R55;
    end else if (irq_enabled_r & general_irq_in_s) begin
      pick = 3'h5;
    end
  end

  wire take;
  assign take = irq_sample & (pick != 3'h0);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      r75_d_r <= 1'b0;
      trap_d_r <= 1'b0;
      trap_arm_r <= 1'b0;
      rst75_pend_r <= 1'b0;
      irq_mask_r <= `CBI_MASK_RST;
      irq_enabled_r <= `CBI_IE_RST;
      irq_take_r <= 1'b0;
      irq_vec_r <= `CBI_VEC_NONE;
      irq_ext_r <= 1'b0;
    end else begin
      r75_d_r <= r75_s;
      trap_d_r <= trap_s;
      // a new edge wins over the clear of the same cycle
      if (trap_rise) begin
        trap_arm_r <= 1'b1;
      end else if (take & (pick == 3'h1)) begin
        trap_arm_r <= 1'b0;
      end
      if (r75_rise) begin
        rst75_pend_r <= 1'b1;
      end else if ((take & (pick == 3'h2)) |
                   (mask_set_instruction & mask_set_data[`CBI_SIM_R75CLR])) begin
        rst75_pend_r <= 1'b0;
      end
      if (mask_set_instruction & mask_set_data[`CBI_SIM_MSE]) begin
        irq_mask_r <= mask_set_data[`CBI_SIM_MASK_HI:`CBI_SIM_MASK_LO];
      end
      // enable instruction wins if it lands with an accept
      if (enable_irq_instruction) begin
        irq_enabled_r <= 1'b1;
      end else if (take | disable_irq_instruction) begin
        irq_enabled_r <= 1'b0;
      end
      irq_take_r <= take;
      if (take) begin
        irq_vec_r <= vec;
        irq_ext_r <= (pick == 3'h5);
      end
    end
  end
endmodule // cbi_bus_irq

/* cbi_regs.vh */
`ifndef CBI_REGS_VH
`define CBI_REGS_VH
// ----------------------------------------
// machine cycle types from the core
// ----------------------------------------
`define CBI_CYC_MRD 3'h0
`define CBI_CYC_MWR 3'h1
`define CBI_CYC_IORD 3'h2
`define CBI_CYC_IOWR 3'h3
`define CBI_CYC_FETCH 3'h4
`define CBI_CYC_IRQ_ACKNOWLEDGE_N 3'h5
// ----------------------------------------
// encoded cycle status {high,low}
// ----------------------------------------
`define CBI_ST_HALT 2'h0
`define CBI_ST_WRITE 2'h1
`define CBI_ST_READ 2'h2
`define CBI_ST_FETCH 2'h3
// ----------------------------------------
// restart addresses
// ----------------------------------------
`define CBI_VEC_TRAP 8'h24
`define CBI_VEC_R55 8'h2C
`define CBI_VEC_R65 8'h34
`define CBI_VEC_R75 8'h3C
`define CBI_VEC_NONE 8'h00
// ----------------------------------------
// mask-set data fields and reset values
// ----------------------------------------
`define CBI_SIM_MASK_LO 0
`define CBI_SIM_MASK_HI 2
`define CBI_SIM_MSE 3
`define CBI_SIM_R75CLR 4
`define CBI_MASK_RST 3'h7
`define CBI_IE_RST 1'b0
`endif

/* cbi_bus_irq_asserts.sv */
`timescale 1ns/1ns
module cbi_bus_irq_chk (
  input wire sys_clk,
  input wire rst_n,
  input wire shared_addr_data_oe_n,
  input wire upper_address_oe_n,
  input wire ale_r,
  input wire cycle_status_low,
  input wire cycle_status_high,
  input wire io_m_r,
  input wire io_m_oe_n,
  input wire rd_n_r,
  input wire rd_oe_n,
  input wire wr_n_r,
  input wire wr_oe_n,
  input wire irq_acknowledge_n,
  input wire bus_grant_out,
  input wire irq_take_r,
  input wire [7:0] irq_vec_r,
  input wire irq_ext_r
);
  wire [1:0] st = {cycle_status_high, cycle_status_low};
  wire off = &{shared_addr_data_oe_n, upper_address_oe_n, rd_oe_n, wr_oe_n, io_m_oe_n};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // strobe and bus phase relations
  ale_one_clk_a: assert property (ale_r |=> !ale_r) else $error("ale too wide");
  addr_phase_a: assert property (
    ale_r |-> !shared_addr_data_oe_n && !upper_address_oe_n)
    else $error("address not driven in first clock");
  write_data_a: assert property (
    $fell(wr_n_r) |-> !shared_addr_data_oe_n && st == 2'h1 ##1 !wr_n_r)
    else $error("write strobe without data");
  read_float_a: assert property (
    $fell(rd_n_r) |-> shared_addr_data_oe_n && st[1] ##1 !rd_n_r)
    else $error("read strobe with bus driven");
  strobe_excl_a: assert property (
    !rd_n_r |-> wr_n_r && irq_acknowledge_n)
    else $error("two strobes low");
  ack_cycle_a: assert property (
    !irq_acknowledge_n |-> rd_n_r && io_m_r && st == 2'h3)
    else $error("bad acknowledge cycle");
  hold_float_a: assert property (
    bus_grant_out && $past(bus_grant_out) |-> off)
    else $error("buses driven under grant");
  vec_legal_a: assert property (
    irq_take_r |-> (irq_ext_r ? irq_vec_r == 8'h00 :
    irq_vec_r inside {8'h24, 8'h2C, 8'h34, 8'h3C})) else $error("bad vector");
  reset_float_a: assert property (
    disable iff (1'b0) !rst_n |=> off && !bus_grant_out)
    else $error("pins driven in reset");
  // main scenarios reached
  cover property (!wr_n_r);
  cover property (!irq_acknowledge_n);
  cover property (bus_grant_out);
  cover property (irq_take_r && !irq_ext_r);
endmodule // cbi_bus_irq_chk
bind cbi_bus_irq cbi_bus_irq_chk i_chk (.sys_clk, .rst_n, .shared_addr_data_oe_n,
  .upper_address_oe_n, .ale_r, .cycle_status_low, .cycle_status_high, .io_m_r, .io_m_oe_n,
  .rd_n_r, .rd_oe_n, .wr_n_r, .wr_oe_n, .irq_acknowledge_n, .bus_grant_out, .irq_take_r,
  .irq_vec_r, .irq_ext_r);

/* cbi_mem_model.sv */
`timescale 1ns/1ns
module cbi_mem_model (
  input wire sys_clk,
  input wire slow,
  input wire ale_r,
  input wire rd_n_r,
  input wire wr_n_r,
  input wire irq_acknowledge_n,
  input wire [7:0] shared_addr_data_bus,
  input wire shared_addr_data_oe_n,
  output wire ready_in,
  output wire [7:0] pin_out
);
  reg [7:0] mem_r [0:255];
  reg [7:0] adr_r;
  reg [7:0] last_r;
  reg [3:0] cnt_r;
  wire drv = !rd_n_r || !irq_acknowledge_n;
  // address taken while the strobe is up, data on every clock the write strobe is low
  always @(posedge sys_clk) begin
    if (ale_r) adr_r <= shared_addr_data_bus;
    if (!wr_n_r) mem_r[adr_r] <= shared_addr_data_bus;
    cnt_r <= (rd_n_r && wr_n_r) ? 4'h0 : cnt_r + 4'h1;
    last_r <= pin_out;
  end
  // slow mode stalls until a few clocks into the strobe
  assign ready_in = !slow || cnt_r >= 4'h3;
  // undriven bus toggles so a stale value never looks valid
  assign pin_out = !shared_addr_data_oe_n ? shared_addr_data_bus : !drv ? ~last_r :
    !irq_acknowledge_n ? 8'hFF : mem_r[adr_r];
endmodule // cbi_mem_model

/* cbi_bus_irq_tb.sv */
`timescale 1ns/1ns
module cbi_bus_irq_tb;
  reg sys_clk, rst_n, cyc_req, halt_req, irq_sample, enable_irq_instruction, slow;
  reg disable_irq_instruction, mask_set_instruction, hold_in, general_irq_in;
  reg rst55_in, rst65_in, rst75_in, trap_in;
  reg [2:0] cyc_type;
  reg [15:0] cyc_addr, n;
  reg [7:0] cyc_wdata, mask_set_data, rd_v;
  wire [7:0] shared_addr_data_bus, upper_address_out, cyc_rdata_r, irq_vec_r, shared_addr_data_in;
  wire [2:0] irq_mask_r;
  wire shared_addr_data_oe_n, upper_address_oe_n, ale_r, cycle_status_low, cycle_status_high;
  wire io_m_r, io_m_oe_n, rd_n_r, rd_oe_n, wr_n_r, wr_oe_n, irq_acknowledge_n, bus_grant_out;
  wire cyc_done_r, irq_take_r, irq_ext_r, irq_enabled_r, rst75_pend_r, ready_in;
  wire [4:0] offs = {shared_addr_data_oe_n, upper_address_oe_n, rd_oe_n, wr_oe_n, io_m_oe_n};
  integer errors = 0, total_checks = 0, cyc_n = 0;
  cbi_bus_irq i_dut (.sys_clk, .rst_n, .cyc_req, .cyc_type, .cyc_addr, .cyc_wdata, .halt_req,
    .irq_sample, .enable_irq_instruction, .disable_irq_instruction, .mask_set_instruction,
    .mask_set_data, .ready_in, .hold_in, .general_irq_in, .rst55_in, .rst65_in, .rst75_in,
    .trap_in, .shared_addr_data_in, .shared_addr_data_bus, .shared_addr_data_oe_n,
    .upper_address_out, .upper_address_oe_n, .ale_r, .cycle_status_low, .cycle_status_high,
    .io_m_r, .io_m_oe_n, .rd_n_r, .rd_oe_n, .wr_n_r, .wr_oe_n, .irq_acknowledge_n,
    .bus_grant_out, .cyc_done_r, .cyc_rdata_r, .irq_take_r, .irq_vec_r, .irq_ext_r,
    .irq_enabled_r, .irq_mask_r, .rst75_pend_r);
  cbi_mem_model i_mem (.sys_clk, .slow, .ale_r, .rd_n_r, .wr_n_r, .irq_acknowledge_n,
    .shared_addr_data_bus, .shared_addr_data_oe_n, .ready_in, .pin_out(shared_addr_data_in));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input [15:0] seen, input [15:0] exp, input [8*10:1] what);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %0s exp %h seen %h", what, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one machine cycle; n counts edges from request to done
  task bus(input [2:0] t, input [15:0] a, input [7:0] d);
    n = 0;
    @(posedge sys_clk);
    {cyc_req, cyc_type, cyc_addr, cyc_wdata} <= {1'b1, t, a, d};
    while (cyc_done_r !== 1'b1 && n < 16'h28) begin
      @(posedge sys_clk);
      #1;
      n = n + 16'h1;
      if (ale_r === 1'b1 && t != 3'h5) check(upper_address_out, a[15:8], "upper");
    end
    rd_v = cyc_rdata_r;
    @(posedge sys_clk);
    cyc_req <= 1'b0;
  endtask
  task wait_grant(input v);
    n = 0;
    while (bus_grant_out !== v && n < 16'h14) begin
      @(posedge sys_clk);
      #1;
      n = n + 16'h1;
    end
    check(bus_grant_out, v, "grant");
  endtask
  task sim(input [7:0] d);
    @(posedge sys_clk);
    {mask_set_instruction, mask_set_data} <= {1'b1, d};
    @(posedge sys_clk);
    mask_set_instruction <= 1'b0;
  endtask
  // lv is {trap, 7.5, 6.5, 5.5, general}; exp is {take, vector}
  task irq(input [4:0] lv, input en, input [8:0] exp);
    @(posedge sys_clk);
    {trap_in, rst75_in, rst65_in, rst55_in, general_irq_in} <= lv;
    enable_irq_instruction <= en;
    @(posedge sys_clk);
    enable_irq_instruction <= 1'b0;
    repeat (3) @(posedge sys_clk);
    irq_sample <= 1'b1;
    @(posedge sys_clk);
    irq_sample <= 1'b0;
    #1;
    check({irq_take_r, exp[8] ? irq_vec_r : 8'h00}, exp,
      "take");
    @(posedge sys_clk);
    #1;
    // every take leaves enable low; only the enable pulse raises it
    check(irq_enabled_r, en & !exp[8], "enable");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_rw;
    bus(3'h1, 16'h3A5C, 8'h96);
    check(n, 16'h5, "wr len");
    bus(3'h4, 16'h3A5C, 8'h00);
    check(rd_v, 8'h96, "fetch");
    bus(3'h3, 16'h4545, 8'hC3);
    slow = 1'b1;
    bus(3'h2, 16'h4545, 8'h00);
    slow = 1'b0;
    check({rd_v, 7'h0, n > 16'h5}, 16'hC301, "slow rd");
  endtask
  task t_hold;
    fork
      bus(3'h1, 16'h1177, 8'h3E);
      begin
        repeat (3) @(posedge sys_clk);
        hold_in <= 1'b1;
      end
    join
    check(n, 16'h5, "held cyc");
    wait_grant(1'b1);
    repeat (8) @(posedge sys_clk);
    #1;
    check({bus_grant_out, offs}, 16'h3F, "hold");
    @(posedge sys_clk);
    hold_in <= 1'b0;
    wait_grant(1'b0);
    bus(3'h0, 16'h1177, 8'h00);
    check(rd_v, 8'h3E, "retake");
    // halted and idle: status reads halt, all five output enables float
    halt_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check({cycle_status_high, cycle_status_low, offs}, 16'h1F, "halt");
    @(posedge sys_clk);
    halt_req <= 1'b0;
  endtask
  task t_irq;
    sim(8'h08);
    irq(5'h1F, 1'b1, 9'h124);
    irq(5'h0F, 1'b1, 9'h13C);
    irq(5'h07, 1'b1, 9'h134);
    irq(5'h03, 1'b1, 9'h12C);
    irq(5'h01, 1'b1, 9'h100);
    check(irq_ext_r, 1'b1, "ext");
    bus(3'h5, 16'h0000, 8'h00);
    check(rd_v, 8'hFF, "ack data");
    irq(5'h01, 1'b0, 9'h000);
    irq(5'h10, 1'b0, 9'h124);
    irq(5'h10, 1'b0, 9'h000);
    sim(8'h0F);
    irq(5'h0C, 1'b1, 9'h000);
    check({rst75_pend_r, irq_mask_r}, 4'hF, "pend");
    // software disable pulse drops the enable left by the last call
    @(posedge sys_clk);
    disable_irq_instruction <= 1'b1;
    @(posedge sys_clk);
    disable_irq_instruction <= 1'b0;
    #1;
    check(irq_enabled_r, 1'b0, "disable");
    sim(8'h1F);
    #1;
    check(rst75_pend_r, 1'b0, "sim clr");
  endtask
  // free-running clock and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 20000) begin
      errors = errors + 1;
      final_report;
    end
  end
  // reset, then each scenario in turn
  initial begin
    {sys_clk, rst_n, cyc_req, halt_req, irq_sample, enable_irq_instruction, slow} = '0;
    {disable_irq_instruction, mask_set_instruction, hold_in, general_irq_in} = '0;
    {rst55_in, rst65_in, rst75_in, trap_in, cyc_type, cyc_addr, cyc_wdata, mask_set_data} = '0;
    repeat (16) @(posedge sys_clk);
    #1;
    check({offs, irq_enabled_r, rst75_pend_r, irq_mask_r}, 16'h3E7,
      "reset");
    @(posedge sys_clk);
    rst_n <= 1'b1;
    t_rw;
    t_hold;
    t_irq;
    final_report;
  end
endmodule // cbi_bus_irq_tb
